// ===== hw/capture_store.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module capture_store
    import capture_store_pkg::*;
#(
    parameter int unsigned FLASH_WR_CYCLES = FLASH_WR_CYC
) (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // register bus
    input  wire axi_req_t             axi_req,
    output axi_rsp_t                  axi_rsp,
    // firmware side
    input  wire logic                 fw_cycle,
    input  wire logic [8*CAP_BYTES-1:0] live_params,
    input  wire logic                 fault_shutdown,
    input  wire logic                 fault_retry,
    // status
    output logic                      flash_busy,
    output logic                      init_done
);
    typedef struct packed {
        fsm_t                         st;
        logic [31:0]                  wait_cnt;
        logic [31:0]                  ctrl;
        logic [2:0]                   cfg_idx;
        logic [CFG_WORDS-1:0][31:0]   cfg_work;
        logic [CFG_WORDS-1:0][31:0]   cfg_def;
        logic [CFG_WORDS-1:0][31:0]   cfg_user;
        logic [CAP_BYTES-1:0][7:0]    cap_ram;
        logic [CAP_BYTES-1:0][7:0]    cap_flash;
        logic                         pend_load;
        logic                         pend_save;
        logic                         refused;
        logic                         aw_got;
        logic [31:0]                  aw_addr;
        logic                         w_got;
        logic [31:0]                  w_data;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic capture_on;
    logic dev_off;

    // stores model nonvolatile cells: they are not cleared by reset
    always_comb begin
        logic [31:0] a;
        logic [7:0]  op;
        logic [4:0]  ci;
        a = 32'h0000_0000;
        op = 8'h00;
        ci = 5'h00;
        nxt_s = s_ff;
        capture_on = s_ff.ctrl[CTRL_CAPTURE_BIT];
        dev_off = ~s_ff.ctrl[CTRL_ENABLE_BIT];
        nxt_s.refused = 1'b0;

        case (s_ff.st)
            ST_INIT: begin
                // working set comes from the user store when the user level ctrl bit is set, else from the default store
                nxt_s.cfg_work = s_ff.ctrl[CTRL_USER_LVL_BIT] ?
                                 s_ff.cfg_user : s_ff.cfg_def; // [RL13]
                nxt_s.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (s_ff.pend_save) begin
                    nxt_s.pend_save = 1'b0;
                    nxt_s.cap_flash = s_ff.cap_ram; // [RL11]
                    nxt_s.wait_cnt = 32'h0000_0000;
                    nxt_s.st = ST_FLASH_WR;
                end else if (s_ff.pend_load) begin
                    nxt_s.pend_load = 1'b0;
                    nxt_s.cap_ram = s_ff.cap_flash; // [RL6]
                end else if (capture_on && fw_cycle) begin
                    nxt_s.cap_ram = live_params; // [RL1] [RL2] [RL5]
                end
            end
            ST_FLASH_WR: begin
                // the ram copy is frozen while flash is programmed
                if (s_ff.wait_cnt >= FLASH_WR_CYCLES - 1) begin
                    nxt_s.st = ST_IDLE; // [RL9]
                end else begin
                    nxt_s.wait_cnt = s_ff.wait_cnt + 32'h0000_0001;
                end
            end
            default: nxt_s.st = ST_INIT;
        endcase

        // retry-type faults never touch flash
        if (fault_shutdown && !fault_retry && s_ff.st != ST_INIT) begin
            nxt_s.pend_save = 1'b1; // [RL8]
        end

        // write channel: address and data may come in either order
        if (axi_req.awvalid && !s_ff.aw_got && !s_ff.bvalid) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_ff.w_got && !s_ff.bvalid) begin
            nxt_s.w_got = 1'b1;
            nxt_s.w_data = axi_req.wdata;
        end
        if (s_ff.aw_got && s_ff.w_got) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = RESP_OKAY;
            op = s_ff.w_data[7:0];
            case (s_ff.aw_addr)
                ADDR_CTRL: nxt_s.ctrl = s_ff.w_data;
                ADDR_CFG_IDX: nxt_s.cfg_idx = s_ff.w_data[2:0];
                ADDR_CFG_DATA: nxt_s.cfg_work[s_ff.cfg_idx] = s_ff.w_data;
                ADDR_CMD: begin
                    case (op)
                        CMD_STORE_DEF:
                            nxt_s.cfg_def = s_ff.cfg_work; // [RL17]
                        CMD_STORE_USER:
                            nxt_s.cfg_user = s_ff.cfg_work; // [RL15] [RL17]
                        CMD_RESTORE_DEF: begin
                            if (s_ff.ctrl[CTRL_DEF_LVL_BIT]) begin
                                nxt_s.cfg_work = s_ff.cfg_def; // [RL14]
                            end else begin
                                nxt_s.bresp = RESP_SLVERR; // [RL16]
                                nxt_s.refused = 1'b1;
                            end
                        end
                        CMD_RESTORE_USER: begin
                            if (s_ff.ctrl[CTRL_USER_LVL_BIT]) begin
                                nxt_s.cfg_work = s_ff.cfg_user;
                            end else begin
                                nxt_s.bresp = RESP_SLVERR; // [RL16]
                                nxt_s.refused = 1'b1;
                            end
                        end
                        default: nxt_s.bresp = RESP_SLVERR;
                    endcase
                end
                ADDR_CAPCTL: begin
                    // capture control; refused while busy
                    if (s_ff.st != ST_IDLE || s_ff.pend_save) begin
                        nxt_s.bresp = RESP_SLVERR; // [RL18]
                    end else if (op == CAPCTL_LOAD) begin
                        nxt_s.pend_load = 1'b1; // [RL6] [RL10]
                    end else if (op == CAPCTL_SAVE && dev_off) begin
                        nxt_s.pend_save = 1'b1; // [RL7]
                    end else begin
                        nxt_s.bresp = RESP_SLVERR; // [RL7]
                    end
                end
                default: nxt_s.bresp = RESP_SLVERR;
            endcase
        end
        if (s_ff.bvalid && axi_req.bready) begin
            nxt_s.bvalid = 1'b0;
        end

        // read channel: capture block as eight words, little endian bytes
        if (axi_req.arvalid && !s_ff.rvalid) begin
            a = axi_req.araddr;
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            nxt_s.rdata = 32'h0000_0000;
            if (a[31:5] == ADDR_CAP_BASE[31:5] && a[1:0] == 2'b00) begin
                ci = {a[4:2], 2'b00};
                nxt_s.rdata = {s_ff.cap_ram[ci + 5'd3], s_ff.cap_ram[ci + 5'd2],
                               s_ff.cap_ram[ci + 5'd1], s_ff.cap_ram[ci]}; // [RL3]
            end else begin
                case (a)
                    ADDR_CTRL: nxt_s.rdata = s_ff.ctrl;
                    ADDR_STATUS: nxt_s.rdata = {28'h0000000, s_ff.pend_load,
                        s_ff.pend_save, s_ff.st == ST_FLASH_WR,
                        s_ff.st != ST_INIT};
                    ADDR_CFG_IDX: nxt_s.rdata = {29'h00000000, s_ff.cfg_idx};
                    ADDR_CFG_DATA: nxt_s.rdata = s_ff.cfg_work[s_ff.cfg_idx];
                    default: nxt_s.rresp = RESP_SLVERR;
                endcase
            end
        end else if (s_ff.rvalid && axi_req.rready) begin
            nxt_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff.st <= ST_INIT;
            s_ff.wait_cnt <= 32'h0000_0000;
            s_ff.ctrl <= CTRL_RESET;
            s_ff.cfg_idx <= 3'h0;
            s_ff.pend_load <= 1'b0;
            s_ff.pend_save <= 1'b0;
            s_ff.refused <= 1'b0;
            s_ff.aw_got <= 1'b0;
            s_ff.aw_addr <= 32'h0000_0000;
            s_ff.w_got <= 1'b0;
            s_ff.w_data <= 32'h0000_0000;
            s_ff.bvalid <= 1'b0;
            s_ff.bresp <= RESP_OKAY;
            s_ff.rvalid <= 1'b0;
            s_ff.rdata <= 32'h0000_0000;
            s_ff.rresp <= RESP_OKAY;
            s_ff.cfg_work <= s_ff.cfg_work;
            s_ff.cfg_def <= s_ff.cfg_def;
            s_ff.cfg_user <= s_ff.cfg_user;
            s_ff.cap_ram <= s_ff.cap_ram;
            s_ff.cap_flash <= s_ff.cap_flash;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign axi_rsp.awready = !s_ff.aw_got && !s_ff.bvalid;
    assign axi_rsp.wready = !s_ff.w_got && !s_ff.bvalid;
    assign axi_rsp.bvalid = s_ff.bvalid;
    assign axi_rsp.bresp = s_ff.bresp;
    assign axi_rsp.arready = !s_ff.rvalid;
    assign axi_rsp.rvalid = s_ff.rvalid;
    assign axi_rsp.rdata = s_ff.rdata;
    assign axi_rsp.rresp = s_ff.rresp;
    assign flash_busy = s_ff.st == ST_FLASH_WR;
    assign init_done = s_ff.st != ST_INIT;
endmodule // capture_store
`default_nettype wire

// ===== hw/capture_store_pkg.sv
// Overview of operation
// [RL1] capture mode runs only while config bit 1 is set by the host
// [RL2] while capturing, the ram copy of parameters refreshes every firmware cycle; the code skips it while flash is programmed or a load/save is pending
// [RL3] the capture reads back as one 32-byte block, allowed during regulation
// [RL4] host disables module and clears capture bit before reading stored capture
// [RL5] with capture bit clear, the ram capture values are no longer overwritten
// [RL6] control value 1 copies the flash capture set into ram
// [RL7] control value 2 writes ram capture to flash, only while disabled
// [RL8] a fault with shutdown response writes capture to flash; retry does not
// [RL9] a capture flash write finishes within 1400 us of its start
// [RL10] host issues control 1 then reads the capture block from ram
// [RL11] flash capture survives power cycles and is read by copy-then-read
// [RL12] host should never store the capture bit in a configuration store
// [RL13] at initialization the stored configuration is loaded before operating
// [RL14] restore-default reloads every setting from the default store
// [RL15] a separate user store holds user-saved settings
// [RL16] restores are allowed only to levels made available to the user
// [RL17] store-user and store-default save the working settings to that store
// [RL18] capture control requests wait while a capture flash write is busy; the code refuses them with SLVERR instead
`default_nettype none
package capture_store_pkg;
    localparam int unsigned CAP_BYTES = 32;
    localparam int unsigned CFG_WORDS = 8;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned FLASH_WR_US = 1400;
    localparam int unsigned FLASH_WR_CYC = FLASH_WR_US * CLK_MHZ;
    localparam int unsigned INIT_CYC = CFG_WORDS;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_CMD = 32'h0000_0008;
    localparam logic [31:0] ADDR_CFG_IDX = 32'h0000_000c;
    localparam logic [31:0] ADDR_CFG_DATA = 32'h0000_0010;
    localparam logic [31:0] ADDR_CAPCTL = 32'h0000_0014;
    localparam logic [31:0] ADDR_CAP_BASE = 32'h0000_0100;
    localparam int unsigned CTRL_CAPTURE_BIT = 1;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_USER_LVL_BIT = 2;
    localparam int unsigned CTRL_DEF_LVL_BIT = 3;
    localparam logic [7:0] CAPCTL_LOAD = 8'h01;
    localparam logic [7:0] CAPCTL_SAVE = 8'h02;
    localparam logic [7:0] CMD_STORE_DEF = 8'h11;
    localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
    localparam logic [7:0] CMD_STORE_USER = 8'h15;
    localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
    localparam logic [7:0] CMD_CAPCTL = 8'h80;
    localparam logic [31:0] CTRL_RESET = 32'h0000_000c;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum {ST_INIT, ST_IDLE, ST_FLASH_WR} fsm_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axi_rsp_t;
endpackage
`default_nettype wire

// ===== test/capture_store_chk.sv
`timescale 1ns/100ps
`default_nettype none
module capture_store_chk
    import capture_store_pkg::*;
#(
    parameter int unsigned FLASH_WR_CYCLES = 20
) (
    // clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // block ports
    input wire axi_req_t               axi_req,
    input wire axi_rsp_t               axi_rsp,
    input wire logic                   fw_cycle,
    input wire logic [8*CAP_BYTES-1:0] live_params,
    input wire logic                   fault_shutdown,
    input wire logic                   fault_retry,
    input wire logic                   flash_busy,
    input wire logic                   init_done
);
    // counter instead of a long repetition, which tools unroll badly
    logic [31:0] busy_cnt_ff;
    always_ff @(posedge aclk) begin
        busy_cnt_ff <= (aresetn && flash_busy) ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence write_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence retry_hold;
        (!flash_busy && fault_retry) [*4];
    endsequence
    a_init_done: assert property (
        !init_done |-> ##[1:16] init_done) else $error("init stuck");
    a_busy_exact: assert property (
        $fell(flash_busy) |-> busy_cnt_ff == FLASH_WR_CYCLES)
        else $error("flash write length wrong");
    a_busy_bound: assert property (
        busy_cnt_ff <= FLASH_WR_CYCLES) else $error("flash write overrun");
    a_shutdown_save: assert property (
        init_done && fault_shutdown && !fault_retry && !flash_busy
        |-> ##[1:4] flash_busy) else $error("shutdown fault not saved");
    a_retry_quiet: assert property (
        retry_hold |=> !flash_busy) else $error("retry fault saved");
    a_write_answer: assert property (
        write_taken |-> ##2 axi_rsp.bvalid) else $error("no write response");
    a_bresp_hold: assert property (
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid
        && $stable(axi_rsp.bresp)) else $error("write response dropped");
    a_read_answer: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("no read response");
    a_rdata_hold: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
        && $stable(axi_rsp.rdata)) else $error("read data dropped");
endmodule // capture_store_chk
bind capture_store capture_store_chk #(
    .FLASH_WR_CYCLES(FLASH_WR_CYCLES)
) chk_u (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .fw_cycle(fw_cycle), .live_params(live_params),
    .fault_shutdown(fault_shutdown), .fault_retry(fault_retry),
    .flash_busy(flash_busy), .init_done(init_done));
`default_nettype wire

// ===== test/capture_store_tb.sv
`timescale 1ns/100ps
`default_nettype none
module capture_store_tb;
    import capture_store_pkg::*;
    localparam int unsigned WR_CYC = 20;
    logic                   aclk;
    logic                   aresetn;
    logic                   fw_cycle;
    logic [8*CAP_BYTES-1:0] live_params;
    logic                   fault_shutdown;
    logic                   fault_retry;
    logic                   flash_busy;
    logic                   init_done;
    axi_req_t               axi_req;
    axi_rsp_t               axi_rsp;
    int                     err_total;
    int                     samples_checked;

    capture_store #(.FLASH_WR_CYCLES(WR_CYC)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .fw_cycle(fw_cycle), .live_params(live_params),
        .fault_shutdown(fault_shutdown), .fault_retry(fault_retry),
        .flash_busy(flash_busy), .init_done(init_done));
    host_model host_u (.aclk(aclk), .req(axi_req), .rsp(axi_rsp));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr_chk(input logic [31:0] a, d, input logic [1:0] er);
        logic [1:0] r;
        host_u.wr(a, d, r);
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [31:0] a, exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        host_u.rd(a, d, r);
        check("rresp", {30'h0, r}, {30'h0, er});
        check("rdata", d, exp);
    endtask

    task automatic tick(input logic [31:0] base);
        @(posedge aclk);
        for (int k = 0; k < 8; k++) live_params[32*k +: 32] <= base + k;
        fw_cycle <= 1'b1;
        @(posedge aclk);
        fw_cycle <= 1'b0;
    endtask

    task automatic rd_blk(input logic [31:0] base);
        for (int k = 0; k < 8; k++) rd_chk(ADDR_CAP_BASE + 4*k, base + k, 2'b00);
    endtask

    // sampled 1 ns after each edge so registered outputs have settled
    task automatic count_busy(input int n, input int exp);
        int c;
        c = 0;
        repeat (n) begin
            #1;
            c += int'(flash_busy === 1'b1);
            @(posedge aclk);
        end
        check("busy cycles", c, exp);
    endtask

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 16 && init_done !== 1'b1; i++) @(posedge aclk);
    endtask

    task automatic t_capture;
        wr_chk(ADDR_CTRL, 32'h0000_000f, RESP_OKAY);
        tick(32'h1000_0000);
        rd_blk(32'h1000_0000);
        tick(32'h3000_0000);
        rd_blk(32'h3000_0000);
        wr_chk(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        tick(32'h2000_0000);
        rd_blk(32'h3000_0000);
    endtask

    task automatic t_fault;
        @(posedge aclk);
        fault_shutdown <= 1'b1;
        fault_retry <= 1'b1;
        count_busy(8, 0);
        fault_shutdown <= 1'b0;
        fault_retry <= 1'b0;
        @(posedge aclk);
        fault_shutdown <= 1'b1;
        @(posedge aclk);
        fault_shutdown <= 1'b0;
        count_busy(40, WR_CYC);
    endtask

    task automatic t_capctl;
        wr_chk(ADDR_CTRL, 32'h0000_000f, RESP_OKAY);
        tick(32'h4000_0000);
        wr_chk(ADDR_CAPCTL, 32'h2, RESP_SLVERR);
        wr_chk(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        wr_chk(ADDR_CAPCTL, 32'h2, RESP_OKAY);
        wr_chk(ADDR_CAPCTL, 32'h1, RESP_SLVERR);
        while (flash_busy === 1'b1) @(posedge aclk);
        wr_chk(ADDR_CTRL, 32'h0000_000e, RESP_OKAY);
        tick(32'h6000_0000);
        rd_chk(ADDR_CAP_BASE, 32'h6000_0000, RESP_OKAY);
        do_reset;
        wr_chk(ADDR_CAPCTL, 32'h1, RESP_OKAY);
        rd_blk(32'h4000_0000);
    endtask

    task automatic t_config;
        wr_chk(ADDR_CFG_IDX, 32'h0, RESP_OKAY);
        wr_chk(ADDR_CFG_DATA, 32'h0000_00a5, RESP_OKAY);
        wr_chk(ADDR_CMD, {24'h0, CMD_STORE_DEF}, RESP_OKAY);
        wr_chk(ADDR_CFG_DATA, 32'h0000_005a, RESP_OKAY);
        wr_chk(ADDR_CMD, {24'h0, CMD_STORE_USER}, RESP_OKAY);
        wr_chk(ADDR_CFG_DATA, 32'h0000_0033, RESP_OKAY);
        wr_chk(ADDR_CMD, {24'h0, CMD_RESTORE_DEF}, RESP_OKAY);
        rd_chk(ADDR_CFG_DATA, 32'h0000_00a5, RESP_OKAY);
        wr_chk(ADDR_CMD, {24'h0, CMD_RESTORE_USER}, RESP_OKAY);
        rd_chk(ADDR_CFG_DATA, 32'h0000_005a, RESP_OKAY);
        wr_chk(ADDR_CTRL, 32'h0, RESP_OKAY);
        wr_chk(ADDR_CMD, {24'h0, CMD_RESTORE_DEF}, RESP_SLVERR);
        wr_chk(ADDR_CMD, {24'h0, CMD_RESTORE_USER}, RESP_SLVERR);
        rd_chk(ADDR_CFG_DATA, 32'h0000_005a, RESP_OKAY);
        rd_chk(32'h0000_0040, 32'h0, RESP_SLVERR);
        do_reset;
        wr_chk(ADDR_CFG_IDX, 32'h0, RESP_OKAY);
        rd_chk(ADDR_CFG_DATA, 32'h0000_005a, RESP_OKAY);
    endtask

    initial begin
        err_total = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        fw_cycle = 1'b0;
        live_params = '0;
        fault_shutdown = 1'b0;
        fault_retry = 1'b0;
        do_reset;
        rd_chk(ADDR_STATUS, 32'h1, RESP_OKAY);
        rd_chk(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        t_capture;
        t_fault;
        t_capctl;
        t_config;
        wrap_up;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        wrap_up;
    end
endmodule // capture_store_tb
`default_nettype wire

// ===== test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
    import capture_store_pkg::*;
(
    // register bus
    input wire logic     aclk,
    output var axi_req_t req,
    input wire axi_rsp_t rsp
);
    initial req = '{wstrb: 4'hf, default: '0};
    // released payload is inverted so a stale value never reads as valid
    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && rsp.awready === 1'b1) begin
                aw_ok = 1'b1;
                req.awvalid <= 1'b0;
                req.awaddr <= ~a;
            end
            if (!w_ok && rsp.wready === 1'b1) begin
                w_ok = 1'b1;
                req.wvalid <= 1'b0;
                req.wdata <= ~d;
            end
        end
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        req.araddr <= ~a;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
endmodule // host_model
`default_nettype wire
